// File: hw/watchdog_pkg.sv
// constants for the watchdog reset timer
package watchdog_pkg;
    localparam logic [3:0] CTRL_STATUS_OFS  = 4'h0;
    localparam logic [3:0] COUNTER_OFS      = 4'h4;
    localparam logic [3:0] CLOCK_SELECT_OFS = 4'h8;

    localparam int COUNTER_ENABLE_GUARD_BIT = 7;
    localparam int COUNTER_WRITE_ENABLE_BIT = 6;
    localparam int CONTROL_ENABLE_GUARD_BIT = 5;
    localparam int CONTROL_WRITE_ENABLE_BIT = 4;
    localparam int RUN_BIT_GUARD_BIT        = 3;
    localparam int RUN_BIT_BIT              = 2;
    localparam int RESET_FLAG_GUARD_BIT     = 1;
    localparam int OVERFLOW_RESET_FLAG_BIT  = 0;
    localparam int OSC_SELECT_BIT           = 3;

    localparam logic [7:0] COUNTER_RESET       = 8'h00;
    localparam logic [7:0] COUNTER_MAX         = 8'hFF;
    localparam logic [3:0] CLOCK_SELECT_RESET  = 4'hF;
    localparam logic [3:0] CLOCK_SELECT_UPPER  = 4'hF;

    localparam int          PRESCALE_BASE_LOG2 = 6;
    localparam int          PRESCALE_TAPS      = 8;
    localparam int          DIVIDER_WIDTH      = 13;
    localparam int          RESET_OSC_CYCLES   = 256;
    localparam int          RESET_CNT_WIDTH    = 9;
endpackage

// File: hw/watchdog_reset_timer.sv
// watchdog reset timer with avalon-mm register slave
`timescale 1ns/1ps
module watchdog_reset_timer
    import watchdog_pkg::*;
(
    input  wire logic        core_clk_i,
    input  wire logic        rst_i,
    input  wire logic [3:0]  avs_address_i,
    input  wire logic        avs_read_i,
    input  wire logic        avs_write_i,
    input  wire logic [31:0] avs_writedata_i,
    input  wire logic [3:0]  avs_byteenable_i,
    output logic [31:0]      avs_readdata_o,
    output logic             avs_waitrequest_o,
    input  wire logic        osc_tick_i,
    input  wire logic        low_power_mode_i,
    output logic             chip_reset_o
);
    logic                       wait_q;
    logic [31:0]                rdata_q;
    logic [DIVIDER_WIDTH-1:0]   div_q;
    logic                       presc_tick_q;
    logic [7:0]                 counter_q;
    logic                       counter_write_enable_q;
    logic                       control_write_enable_q;
    logic                       run_bit_q;
    logic                       overflow_reset_flag_q;
    logic [3:0]                 clock_select_field_q;
    logic [RESET_CNT_WIDTH-1:0] rst_cnt_q;
    logic                       chip_reset_q;

    logic       access;
    logic       wr_go;
    logic       wr_byte;
    logic [7:0] wd;
    logic       wr_ctrl;
    logic       wr_cnt;
    logic       wr_sel;
    logic       tick;
    logic       overflow;
    logic [7:0] ctrl_rd;
    logic [7:0] tap_mask;

    // request is answered one cycle after it appears
    assign access  = avs_read_i | avs_write_i;
    assign wr_go   = avs_write_i & ~wait_q;
    assign wr_byte = wr_go & avs_byteenable_i[0];
    assign wd      = avs_writedata_i[7:0];
    assign wr_ctrl = wr_byte & (avs_address_i == CTRL_STATUS_OFS);
    assign wr_cnt  = wr_byte & (avs_address_i == COUNTER_OFS);
    assign wr_sel  = wr_byte & (avs_address_i == CLOCK_SELECT_OFS);

    // guard bits always read back as one
    assign ctrl_rd = {1'b1, counter_write_enable_q,
                      1'b1, control_write_enable_q,
                      1'b1, run_bit_q,
                      1'b1, overflow_reset_flag_q};

    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            wait_q <= 1'b1;
        end else if (access && wait_q) begin
            wait_q <= 1'b0;
        end else begin
            wait_q <= 1'b1;
        end
    end

    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            rdata_q <= 32'h0000_0000;
        end else if (avs_read_i && wait_q) begin
            case (avs_address_i)
                CTRL_STATUS_OFS:  rdata_q <= {24'h00_0000, ctrl_rd};
                COUNTER_OFS:      rdata_q <= {24'h00_0000, counter_q};
                CLOCK_SELECT_OFS: rdata_q <= {24'h00_0000,
                    CLOCK_SELECT_UPPER, clock_select_field_q};
                default:          rdata_q <= 32'h0000_0000;
            endcase
        end
    end

    assign avs_readdata_o    = rdata_q;
    assign avs_waitrequest_o = wait_q;

    // free running divider; taps line up so every rate pulses one cycle
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            div_q <= '0;
        end else begin
            div_q <= div_q + 1'b1;
        end
    end

    // constant part-select bounds per tap need a generate loop
    for (genvar k = 0; k < PRESCALE_TAPS; k++) begin : g_tap
        assign tap_mask[k] = &div_q[PRESCALE_BASE_LOG2+k-1:0];
    end

    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            presc_tick_q <= 1'b0;
        end else begin
            presc_tick_q <= tap_mask[clock_select_field_q[2:0]];
        end
    end

    // oscillator keeps counting even in low power modes
    assign tick = clock_select_field_q[OSC_SELECT_BIT]
                ? (presc_tick_q & ~low_power_mode_i)
                : osc_tick_i;
    // only an accepted load suppresses the wrap, else it would go unseen
    assign overflow = run_bit_q & tick
                    & ~(wr_cnt & counter_write_enable_q)
                    & (counter_q == COUNTER_MAX);

    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            clock_select_field_q <= CLOCK_SELECT_RESET;
        end else if (wr_sel) begin
            clock_select_field_q <= wd[3:0];
        end
    end

    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            counter_q <= COUNTER_RESET;
        end else if (wr_cnt && counter_write_enable_q) begin
            counter_q <= wd;
        end else if (run_bit_q && tick) begin
            counter_q <= counter_q + 8'h01;
        end
    end

    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            counter_write_enable_q <= 1'b0;
        end else if (wr_ctrl && !wd[COUNTER_ENABLE_GUARD_BIT]) begin
            counter_write_enable_q <= wd[COUNTER_WRITE_ENABLE_BIT];
        end
    end

    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            control_write_enable_q <= 1'b0;
        end else if (wr_ctrl && !wd[CONTROL_ENABLE_GUARD_BIT]) begin
            control_write_enable_q <= wd[CONTROL_WRITE_ENABLE_BIT];
        end
    end

    // uses the enable held before this write
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            run_bit_q <= 1'b0;
        end else if (wr_ctrl && control_write_enable_q
                     && !wd[RUN_BIT_GUARD_BIT]) begin
            run_bit_q <= wd[RUN_BIT_BIT];
        end
    end

    // overflow set wins over a coincident clear
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            overflow_reset_flag_q <= 1'b0;
        end else if (overflow) begin
            overflow_reset_flag_q <= 1'b1;
        end else if (wr_ctrl && control_write_enable_q
                     && !wd[RESET_FLAG_GUARD_BIT]
                     && !wd[OVERFLOW_RESET_FLAG_BIT]) begin
            overflow_reset_flag_q <= 1'b0;
        end
    end

    // pulse length counted on oscillator ticks, restarted by overflow
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            rst_cnt_q    <= '0;
            chip_reset_q <= 1'b0;
        end else if (overflow) begin
            rst_cnt_q    <= RESET_CNT_WIDTH'(RESET_OSC_CYCLES);
            chip_reset_q <= 1'b1;
        end else if (chip_reset_q && osc_tick_i) begin
            rst_cnt_q    <= rst_cnt_q - 1'b1;
            chip_reset_q <= (rst_cnt_q != 1);
        end
    end

    assign chip_reset_o = chip_reset_q;
endmodule

// File: tb/watchdog_reset_timer_bench.sv
// self-checking bench for the watchdog reset timer
`timescale 1ns/1ps
module watchdog_reset_timer_bench;
    logic        core_clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic [3:0]  avs_address_i = 4'h0;
    logic        avs_read_i = 1'b0;
    logic        avs_write_i = 1'b0;
    logic [31:0] avs_writedata_i = 32'h0;
    logic [3:0]  avs_byteenable_i = 4'h1;
    logic        osc_tick_i = 1'b0;
    logic        low_power_mode_i = 1'b0;
    logic [31:0] avs_readdata_o;
    logic        avs_waitrequest_o;
    logic        chip_reset_o;
    logic [31:0] v;
    int          bad_count = 0;
    int          n_checks = 0;
    int          cyc = 0;
    watchdog_reset_timer i_dut (
        .core_clk_i(core_clk_i), .rst_i(rst_i), .avs_address_i(avs_address_i),
        .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
        .avs_writedata_i(avs_writedata_i),
        .avs_byteenable_i(avs_byteenable_i),
        .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
        .osc_tick_i(osc_tick_i), .low_power_mode_i(low_power_mode_i),
        .chip_reset_o(chip_reset_o));
    initial begin
        forever #2.5 core_clk_i = ~core_clk_i;
    end
    task close_out;
        if (bad_count == 0 && n_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    always @(posedge core_clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 60000) begin
            bad_count = bad_count + 1;
            close_out();
        end
    end
    task chk(input logic [31:0] e, input logic [31:0] g, input logic [3:0] a);
        n_checks = n_checks + 1;
        if (g !== e) begin
            bad_count = bad_count + 1;
            $display("BAD reg %h exp %h got %h", a, e, g);
        end
    endtask
    // waitrequest and readdata are read before the edge lands, as a master
    task acc(input logic [3:0] a, input logic w, input logic [7:0] d);
        @(posedge core_clk_i);
        avs_address_i <= a;
        avs_writedata_i <= {24'h0, d};
        avs_write_i <= w;
        avs_read_i <= !w;
        do @(posedge core_clk_i); while (avs_waitrequest_o !== 1'b0);
        v = avs_readdata_o;
        avs_write_i <= 1'b0;
        avs_read_i <= 1'b0;
    endtask
    task rc(input logic [3:0] a, input logic [31:0] e);
        acc(a, 1'b0, 8'h00);
        chk(e, v, a);
    endtask
    task tick(input int n);
        repeat (n) begin
            @(posedge core_clk_i);
            osc_tick_i <= 1'b1;
            @(posedge core_clk_i);
            osc_tick_i <= 1'b0;
        end
    endtask
    task rst_chk(input logic e);
        repeat (2) @(posedge core_clk_i);
        chk({31'h0, e}, {31'h0, chip_reset_o}, 4'hF);
    endtask
    initial begin
        repeat (10) @(posedge core_clk_i);
        rst_i <= 1'b0;
        rc(4'h0, 32'hAA);
        rc(4'h4, 32'h00);
        rc(4'h8, 32'hFF);
        rc(4'hC, 32'h00);
        acc(4'h4, 1'b1, 8'h55);
        rc(4'h4, 32'h00);
        acc(4'h0, 1'b1, 8'hF7);
        acc(4'h0, 1'b1, 8'hFF);
        rc(4'h0, 32'hAA);
        acc(4'h0, 1'b1, 8'hDB);
        acc(4'h0, 1'b1, 8'h7F);
        rc(4'h0, 32'hFA);
        acc(4'h8, 1'b1, 8'h00);
        rc(4'h8, 32'hF0);
        low_power_mode_i <= 1'b1;
        acc(4'h4, 1'b1, 8'hF0);
        // a write with its low lane disabled must leave the counter alone
        avs_byteenable_i <= 4'h0;
        acc(4'h4, 1'b1, 8'h12);
        avs_byteenable_i <= 4'h1;
        tick(3);
        rc(4'h4, 32'hF0);
        acc(4'h0, 1'b1, 8'hF6);
        rc(4'h0, 32'hFE);
        tick(15);
        rc(4'h4, 32'hFF);
        rst_chk(1'b0);
        tick(1);
        rst_chk(1'b1);
        acc(4'h0, 1'b1, 8'hF2);
        rc(4'h4, 32'h00);
        acc(4'h0, 1'b1, 8'hFE);
        rc(4'h0, 32'hFB);
        tick(254);
        rst_chk(1'b1);
        tick(2);
        rst_chk(1'b0);
        acc(4'h0, 1'b1, 8'hFC);
        rc(4'h0, 32'hFA);
        acc(4'h0, 1'b1, 8'hF6);
        // oscillator tick lands on the very edge at which the load acts
        fork
            acc(4'h4, 1'b1, 8'h80);
            begin
                repeat (2) @(posedge core_clk_i);
                osc_tick_i <= 1'b1;
                @(posedge core_clk_i);
                osc_tick_i <= 1'b0;
            end
        join
        rc(4'h4, 32'h80);
        low_power_mode_i <= 1'b0;
        // a free-running divider gives two or three ticks in two periods
        for (int s = 0; s < 8; s++) begin
            acc(4'h8, 1'b1, 8'h08 | s[7:0]);
            acc(4'h4, 1'b1, 8'h00);
            repeat (2 << (6 + s)) @(posedge core_clk_i);
            acc(4'h4, 1'b0, 8'h00);
            chk(32'h0, v & 32'hFFFF_FFFC, 4'h4);
            chk(32'h1, {31'h0, v == 32'h2 || v == 32'h3}, 4'h4);
        end
        rst_i <= 1'b1;
        repeat (2) @(posedge core_clk_i);
        rst_i <= 1'b0;
        rc(4'h0, 32'hAA);
        rc(4'h4, 32'h00);
        rc(4'h8, 32'hFF);
        close_out();
    end
endmodule

// File: tb/watchdog_reset_timer_checker.sv
// port assertions for the watchdog reset timer
`timescale 1ns/1ps
module watchdog_reset_timer_checker
    import watchdog_pkg::*;
(
    input wire logic        core_clk_i,
    input wire logic        rst_i,
    input wire logic [3:0]  avs_address_i,
    input wire logic        avs_read_i,
    input wire logic        avs_write_i,
    input wire logic [31:0] avs_readdata_o,
    input wire logic        avs_waitrequest_o,
    input wire logic        osc_tick_i,
    input wire logic        chip_reset_o
);
    // oscillator pulses seen while the chip reset is high
    logic [8:0] osc_cnt_q;
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i || !chip_reset_o)
            osc_cnt_q <= 9'h000;
        else if (osc_tick_i)
            osc_cnt_q <= osc_cnt_q + 9'h001;
    end
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (rst_i);
    sequence s_ctrl_rd;
        avs_read_i && !avs_waitrequest_o && avs_address_i == CTRL_STATUS_OFS;
    endsequence
    sequence s_sel_rd;
        avs_read_i && !avs_waitrequest_o && avs_address_i == CLOCK_SELECT_OFS;
    endsequence
    a_guard_seven: assert property (s_ctrl_rd |-> avs_readdata_o[7])
        else $error("guard bit 7 read as 0");
    a_guard_five: assert property (s_ctrl_rd |-> avs_readdata_o[5])
        else $error("guard bit 5 read as 0");
    a_guard_three: assert property (s_ctrl_rd |-> avs_readdata_o[3])
        else $error("guard bit 3 read as 0");
    a_guard_one: assert property (s_ctrl_rd |-> avs_readdata_o[1])
        else $error("guard bit 1 read as 0");
    a_select_upper: assert property (
        s_sel_rd |-> avs_readdata_o[7:4] == 4'hF)
        else $error("clock select upper nibble not ones");
    a_reset_long: assert property (
        chip_reset_o |-> osc_cnt_q < 9'h100)
        else $error("chip reset held too long");
    a_reset_short: assert property (
        $fell(chip_reset_o) |-> osc_cnt_q == 9'h100)
        else $error("chip reset released early");
    a_wait_answer: assert property (
        (avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o)
        else $error("request not answered after one wait");
endmodule
bind watchdog_reset_timer watchdog_reset_timer_checker i_chk (
    .core_clk_i(core_clk_i), .rst_i(rst_i), .avs_address_i(avs_address_i),
    .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
    .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
    .osc_tick_i(osc_tick_i), .chip_reset_o(chip_reset_o));
